// file: hw/dscl_pkg.sv
// Package for the dual serial channel link: constants, codes, command and state types
package dscl_pkg;

  // Timing
  localparam int CLK_NS      = 25;
  localparam int BIT_NS      = 100;
  localparam int BIT_CYC     = BIT_NS / CLK_NS;
  localparam int HALF_CYC    = BIT_CYC / 2;
  localparam int PW_SETUP_NS = 300;
  localparam int PW_XFER_NS  = 600;
  localparam int PW_SETUP_CYC = PW_SETUP_NS / CLK_NS;
  localparam int PW_XFER_CYC  = PW_XFER_NS / CLK_NS;
  localparam int RX_TMO_NS   = 20000;
  localparam int RX_TMO_CYC  = RX_TMO_NS / CLK_NS;

  // Framing
  localparam logic [3:0] CODE_A = 4'h3;
  localparam logic [3:0] CODE_B = 4'h5;
  localparam logic [3:0] CODE_C = 4'h9;
  localparam int LINE_BITS = 18;
  localparam int CODE_BITS = 4;
  localparam int BLK_WORDS = 16;

  // Status bit positions
  localparam int ST_RC_LO  = 0;
  localparam int ST_RC_HI  = 3;
  localparam int ST_BUSY   = 6;
  localparam int ST_OVR    = 7;
  localparam int ST_SEQ    = 8;
  localparam int ST_ILL    = 9;
  localparam int ST_CMD    = 10;
  localparam int ST_CHAN   = 11;
  localparam int ST_MAINT  = 12;
  localparam int ST_WIDTH  = 13;

  // Host read selectors
  localparam logic [1:0] RD_STATUS = 2'h0;
  localparam logic [1:0] RD_INT    = 2'h1;
  localparam logic [1:0] RD_SR     = 2'h2;
  localparam logic [1:0] RD_BUF    = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_RD_WORD   = 4'h1,
    OP_RD_BLOCK  = 4'h2,
    OP_RD_STATUS = 4'h3,
    OP_WR_WORD   = 4'h4,
    OP_WR_BLOCK  = 4'h5,
    OP_WR_CMD    = 4'h6,
    OP_EOT       = 4'h7,
    OP_SET_OVR   = 4'h8,
    OP_CLR_OVR   = 4'h9,
    OP_LD_MINT   = 4'hA,
    OP_LD_MSR    = 4'hB,
    OP_SET_MAINT = 4'hC,
    OP_CLR_MAINT = 4'hD
  } dscl_op_t;

  typedef struct packed {
    dscl_op_t    op;
    logic [5:0]  addr;
    logic        clr_sr;
    logic        clr_int;
    logic [15:0] arg;
  } dscl_cmd_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_TX   = 4'b0010,
    S_RX   = 4'b0100,
    S_CHK  = 4'b1000
  } dscl_state_t;

  typedef enum logic [2:0] {
    PH_CODE = 3'b001,
    PH_DATA = 3'b010,
    PH_DEAD = 3'b100
  } dscl_phase_t;

endpackage : dscl_pkg

// file: hw/dscl_channel.sv
// Dual serial channel: host command port, serial framer/deframer, request receivers
`timescale 1ns/1ps
module dscl_channel
  import dscl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host command port
  input  wire logic        cmd_valid,
  input  wire dscl_cmd_t   cmd,
  input  wire logic        wr_valid,
  input  wire logic [3:0]  wr_index,
  input  wire logic [31:0] wr_data,
  input  wire logic [1:0]  rd_sel,
  input  wire logic [3:0]  rd_index,
  input  wire logic        io_inhibit,
  output logic [35:0]      rd_data,
  output logic             busy,
  output logic             reply_avail,
  output logic             reply_error,
  // Peripheral link
  output logic [15:0]      pd_select,
  output logic             tx_clk,
  output logic             data_hi_o,
  output logic             data_hi_oe,
  input  wire logic        data_hi_i,
  output logic             data_lo_o,
  output logic             data_lo_oe,
  input  wire logic        data_lo_i,
  input  wire logic        rx_clk,
  input  wire logic [15:0] req_in
);

  function automatic logic [35:0] par36(input logic [31:0] d);
    logic [35:0] w;
    w = '0;
    for (int i = 0; i < 4; i++)
    begin
      w[i*9 +: 9] = {~^d[i*8 +: 8], d[i*8 +: 8]};
    end
    return w;
  endfunction : par36

  function automatic logic par_ok(input logic [35:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ok = ok & (^w[i*9 +: 9]);
    end
    return ok;
  endfunction : par_ok

  function automatic logic [4:0] dec3of6(input logic [5:0] c);
    logic [4:0] r;
    r = '0;
    case (c)
      6'h07: r = {1'b1, 4'h0};
      6'h0B: r = {1'b1, 4'h1};
      6'h0D: r = {1'b1, 4'h2};
      6'h0E: r = {1'b1, 4'h3};
      6'h15: r = {1'b1, 4'h4};
      6'h16: r = {1'b1, 4'h5};
      6'h19: r = {1'b1, 4'h6};
      6'h1A: r = {1'b1, 4'h7};
      6'h25: r = {1'b1, 4'h8};
      6'h26: r = {1'b1, 4'h9};
      6'h29: r = {1'b1, 4'hA};
      6'h2A: r = {1'b1, 4'hB};
      6'h31: r = {1'b1, 4'hC};
      6'h32: r = {1'b1, 4'hD};
      6'h34: r = {1'b1, 4'hE};
      6'h38: r = {1'b1, 4'hF};
      default: r = '0;
    endcase
    return r;
  endfunction : dec3of6

  function automatic logic code_ok(input logic [3:0] hi, input logic [3:0] lo);
    return ((hi == CODE_A) || (hi == CODE_B)) && ((lo == CODE_A) || (lo == CODE_B));
  endfunction : code_ok

  // Bit-rate divider
  logic [1:0] div_q;
  logic       bit_en;
  assign bit_en = (div_q == 2'(BIT_CYC - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= '0;
    else
      div_q <= bit_en ? 2'h0 : div_q + 2'h1;
  end

  // Synchronisers for link inputs
  logic [2:0] lnk_s1_q;
  logic [2:0] lnk_s2_q;
  logic       rxc_s3_q;
  logic       rx_edge;
  assign rx_edge = lnk_s2_q[2] & ~rxc_s3_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lnk_s1_q <= '0;
      lnk_s2_q <= '0;
      rxc_s3_q <= 1'b0;
    end
    else
    begin
      lnk_s1_q <= {rx_clk, data_hi_i, data_lo_i};
      lnk_s2_q <= lnk_s1_q;
      rxc_s3_q <= lnk_s2_q[2];
    end
  end

  // Sequencer state
  dscl_state_t  state_q;
  dscl_phase_t  ph_q;
  logic [35:0]  buf_q [BLK_WORDS];
  logic [17:0]  sh_hi_q, sh_lo_q;
  logic [3:0]   rc_hi_q, rc_lo_q;
  logic [4:0]   cnt_q;
  logic [3:0]   widx_q;
  logic [3:0]   last_q;
  logic         rd_q, dat_q, par_bad_q, tail_q;
  logic [9:0]   tmo_q;
  logic         ovr_q, maint_q, seq_err_q, ill_q, cmd_err_q, chan_err_q;
  logic [7:0]   sc;
  logic [4:0]   dec;
  logic         is_xfer;
  logic         code_seen;
  logic         inh;

  assign dec       = dec3of6(cmd.addr);
  assign code_seen = rc_hi_q[0] & rc_lo_q[0];
  assign inh       = io_inhibit & ~ovr_q;

  // Start codes per operation, high then low
  always_comb
  begin
    sc      = '0;
    is_xfer = 1'b1;
    case (cmd.op)
      OP_WR_WORD:   sc = {CODE_A, CODE_A};
      OP_WR_CMD:    sc = {CODE_A, CODE_B};
      OP_WR_BLOCK:  sc = {CODE_A, CODE_C};
      OP_RD_WORD:   sc = {CODE_B, CODE_A};
      OP_RD_STATUS: sc = {CODE_B, CODE_B};
      OP_RD_BLOCK:  sc = {CODE_B, CODE_C};
      OP_EOT:       sc = {CODE_C, CODE_A};
      default:      is_xfer = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      ph_q <= PH_CODE;
      for (int i = 0; i < BLK_WORDS; i++)
        buf_q[i] <= '0;
      sh_hi_q <= '0; sh_lo_q <= '0;
      rc_hi_q <= '0; rc_lo_q <= '0;
      cnt_q <= '0; widx_q <= '0; last_q <= '0;
      rd_q <= 1'b0; dat_q <= 1'b0; par_bad_q <= 1'b0; tmo_q <= '0;
      tail_q <= 1'b0;
      ovr_q <= 1'b0; maint_q <= 1'b0; seq_err_q <= 1'b0; ill_q <= 1'b0;
      cmd_err_q <= 1'b0; chan_err_q <= 1'b0;
      pd_select <= '0; busy <= 1'b0; reply_avail <= 1'b0; reply_error <= 1'b0;
      data_hi_o <= 1'b0; data_lo_o <= 1'b0; data_hi_oe <= 1'b0; data_lo_oe <= 1'b0;
    end
    else
    begin
      reply_avail <= 1'b0;
      reply_error <= 1'b0;
      if (wr_valid && state_q == S_IDLE)
        buf_q[wr_index] <= par36(wr_data);
      case (state_q)
        S_IDLE:
        begin
          if (cmd_valid)
          begin
            case (cmd.op)
              OP_SET_OVR:   ovr_q <= 1'b1;
              OP_CLR_OVR:   ovr_q <= 1'b0;
              OP_SET_MAINT: maint_q <= 1'b1;
              OP_CLR_MAINT: maint_q <= 1'b0;
              OP_NOP, OP_LD_MINT, OP_LD_MSR: ;
              default:
              begin
                if (!is_xfer)
                  cmd_err_q <= 1'b1;
                else if (!dec[4])
                begin
                  ill_q <= 1'b1;
                  cmd_err_q <= 1'b1;
                end
                else
                begin
                  // Control/address load: select device, load start codes, begin shifting
                  pd_select <= 16'h0001 << dec[3:0];
                  sh_hi_q <= {14'h0000, sc[7:4]};
                  sh_lo_q <= {14'h0000, sc[3:0]};
                  rc_hi_q <= '0;
                  rc_lo_q <= '0;
                  cnt_q <= 5'(CODE_BITS - 1);
                  ph_q <= PH_CODE;
                  widx_q <= '0;
                  rd_q <= (cmd.op == OP_RD_WORD) || (cmd.op == OP_RD_BLOCK) || (cmd.op == OP_RD_STATUS);
                  dat_q <= (cmd.op != OP_EOT);
                  last_q <= ((cmd.op == OP_WR_BLOCK) || (cmd.op == OP_RD_BLOCK)) ? 4'(BLK_WORDS - 1) : 4'h0;
                  par_bad_q <= 1'b0;
                  tail_q <= 1'b0;
                  seq_err_q <= 1'b0; ill_q <= 1'b0; cmd_err_q <= 1'b0; chan_err_q <= 1'b0;
                  busy <= 1'b1;
                  data_hi_oe <= ~inh;
                  data_lo_oe <= ~inh;
                  state_q <= S_TX;
                end
              end
            endcase
          end
        end
        S_TX:
        begin
          if (cmd_valid && is_xfer)
            cmd_err_q <= 1'b1;
          if (bit_en && tail_q)
          begin
            // Last bit has stood a full bit time: turn the leads round, clock keeps running
            data_hi_oe <= 1'b0;
            data_lo_oe <= 1'b0;
            ph_q <= PH_CODE;
            widx_q <= '0;
            tmo_q <= '0;
            tail_q <= 1'b0;
            state_q <= S_RX;
          end
          else if (bit_en)
          begin
            // Both lines shift in step, least significant bit first
            data_hi_o <= (ph_q == PH_DEAD) ? 1'b0 : sh_hi_q[0];
            data_lo_o <= (ph_q == PH_DEAD) ? 1'b0 : sh_lo_q[0];
            sh_hi_q <= sh_hi_q >> 1;
            sh_lo_q <= sh_lo_q >> 1;
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h00)
            begin
              if (ph_q == PH_DATA)
              begin
                ph_q <= PH_DEAD;
                cnt_q <= '0;
              end
              else if (!rd_q && dat_q && (ph_q == PH_CODE || widx_q != last_q))
              begin
                // Next word enters the shift register during the dead bit, the first word during the last code bit
                sh_hi_q <= buf_q[(ph_q == PH_CODE) ? widx_q : widx_q + 4'h1][35:18];
                sh_lo_q <= buf_q[(ph_q == PH_CODE) ? widx_q : widx_q + 4'h1][17:0];
                if (ph_q == PH_DEAD)
                  widx_q <= widx_q + 4'h1;
                ph_q <= PH_DATA;
                cnt_q <= 5'(LINE_BITS - 1);
              end
              else
                tail_q <= 1'b1;
            end
          end
        end
        S_RX:
        begin
          if (cmd_valid && is_xfer)
            cmd_err_q <= 1'b1;
          // Timeout measures silence on the return link, so long blocks do not trip it
          tmo_q <= rx_edge ? 10'h000 : tmo_q + 10'h001;
          if (tmo_q == 10'(RX_TMO_CYC - 1))
          begin
            seq_err_q <= 1'b1;
            state_q <= S_CHK;
          end
          else if (ph_q == PH_CODE)
          begin
            if (code_seen)
            begin
              if (rd_q)
              begin
                ph_q <= PH_DATA;
                cnt_q <= 5'(LINE_BITS - 1);
              end
              else
                state_q <= S_CHK;
            end
            else if (rx_edge)
            begin
              rc_hi_q <= {lnk_s2_q[1], rc_hi_q[3:1]};
              rc_lo_q <= {lnk_s2_q[0], rc_lo_q[3:1]};
            end
          end
          else if (rx_edge)
          begin
            if (ph_q == PH_DATA)
            begin
              sh_hi_q <= {lnk_s2_q[1], sh_hi_q[17:1]};
              sh_lo_q <= {lnk_s2_q[0], sh_lo_q[17:1]};
              cnt_q <= cnt_q - 5'h01;
              if (cnt_q == 5'h00)
                ph_q <= PH_DEAD;
            end
            else
            begin
              buf_q[widx_q] <= {sh_hi_q, sh_lo_q};
              if (!par_ok({sh_hi_q, sh_lo_q}))
                par_bad_q <= 1'b1;
              widx_q <= widx_q + 4'h1;
              if (widx_q == last_q)
                state_q <= S_CHK;
              else
              begin
                ph_q <= PH_DATA;
                cnt_q <= 5'(LINE_BITS - 1);
              end
            end
          end
        end
        S_CHK:
        begin
          busy <= 1'b0;
          if (!seq_err_q && code_ok(rc_hi_q, rc_lo_q) && !par_bad_q)
            reply_avail <= 1'b1;
          else
          begin
            reply_error <= 1'b1;
            chan_err_q <= 1'b1;
          end
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Transmit clock runs through transmit and receive, stops with outpulsing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_clk <= 1'b0;
    else
      // Held low until the first code bit stands on the leads
      tx_clk <= ((state_q == S_TX && !(ph_q == PH_CODE && cnt_q == 5'(CODE_BITS - 1))) || state_q == S_RX) &&
                !inh && (div_q < 2'(HALF_CYC));
  end

  // Request receivers
  logic [15:0] req_s1_q, req_s2_q, req_s3_q;
  logic [5:0]  pw_q [16];
  logic [15:0] mask_int_q, mask_sr_q;
  logic [15:0] int_q, sr_setup_q, sr_xfer_q;
  logic [15:0] set_int, set_setup, set_xfer, clr_int, clr_sr;

  always_comb
  begin
    set_int   = '0;
    set_setup = '0;
    set_xfer  = '0;
    for (int i = 0; i < 16; i++)
    begin
      if (req_s3_q[i] && !req_s2_q[i])
      begin
        if (pw_q[i] < 6'(PW_SETUP_CYC))
          set_setup[i] = 1'b1;
        else if (pw_q[i] < 6'(PW_XFER_CYC))
          set_xfer[i] = 1'b1;
        else
          set_int[i] = 1'b1;
      end
    end
    clr_int = (cmd_valid && cmd.clr_int) ? cmd.arg : 16'h0000;
    clr_sr  = (cmd_valid && cmd.clr_sr) ? cmd.arg : 16'h0000;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_s1_q <= '0; req_s2_q <= '0; req_s3_q <= '0;
      for (int i = 0; i < 16; i++)
        pw_q[i] <= '0;
      mask_int_q <= '0; mask_sr_q <= '0;
      int_q <= '0; sr_setup_q <= '0; sr_xfer_q <= '0;
    end
    else
    begin
      req_s1_q <= req_in;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      for (int i = 0; i < 16; i++)
        pw_q[i] <= !req_s2_q[i] ? 6'h00 : (pw_q[i] == 6'h3F) ? pw_q[i] : pw_q[i] + 6'h01;
      if (cmd_valid && cmd.op == OP_LD_MINT)
        mask_int_q <= cmd.arg;
      if (cmd_valid && cmd.op == OP_LD_MSR)
        mask_sr_q <= cmd.arg;
      // New request wins over a clear in the same cycle; mask locks the receiver off
      int_q      <= ((int_q & ~clr_int) | set_int) & ~mask_int_q;
      sr_setup_q <= ((sr_setup_q & ~clr_sr) | set_setup) & ~mask_sr_q;
      sr_xfer_q  <= ((sr_xfer_q & ~clr_sr) | set_xfer) & ~mask_sr_q;
    end
  end

  // Host read port
  logic [ST_WIDTH-1:0] status;
  assign status = {maint_q, chan_err_q, cmd_err_q, ill_q, seq_err_q, ovr_q, busy,
                   rc_hi_q[3:1], rc_lo_q[3:1]};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= '0;
    else
    begin
      case (rd_sel)
        RD_STATUS: rd_data <= {23'h00_0000, status};
        RD_INT:    rd_data <= {20'h0_0000, int_q};
        RD_SR:     rd_data <= {4'h0, sr_xfer_q, sr_setup_q};
        default:   rd_data <= buf_q[rd_index];
      endcase
    end
  end

  // Checks
  logic [8:0] tx_bits_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_bits_q <= '0;
    else if (state_q == S_IDLE)
      tx_bits_q <= '0;
    else if (state_q == S_TX && bit_en && !tail_q)
      tx_bits_q <= tx_bits_q + 9'h001;
  end

  sequence s_turn;
    state_q == S_RX && $past(state_q) == S_TX;
  endsequence
  sequence s_code_done;
    state_q == S_RX && ph_q == PH_CODE && code_seen && !rd_q && tmo_q != 10'(RX_TMO_CYC - 1);
  endsequence

  property p_bit_rate;
    @(posedge clk) disable iff (!rst_n) bit_en |=> !bit_en [*3] ##1 bit_en;
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("bit period not four cycles");

  property p_wr_len;
    @(posedge clk) disable iff (!rst_n) s_turn and (!rd_q && dat_q && last_q == 4'h0) |-> tx_bits_q == 9'h017;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("write word did not send 23 bits");

  property p_rd_len;
    @(posedge clk) disable iff (!rst_n) s_turn and rd_q |-> tx_bits_q == 9'h004;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read did not send 4 bits");

  property p_release;
    @(posedge clk) disable iff (!rst_n) state_q == S_RX |-> !data_hi_oe && !data_lo_oe;
  endproperty
  a_release: assert property (p_release) else $error("data leads driven while receiving");

  property p_rx_clock;
    @(posedge clk) disable iff (!rst_n) (state_q == S_RX && div_q == 2'h0 && !inh) |=> tx_clk;
  endproperty
  a_rx_clock: assert property (p_rx_clock) else $error("transmit clock stopped in receive");

  property p_dead;
    @(posedge clk) disable iff (!rst_n) (state_q == S_TX && ph_q == PH_DEAD && bit_en) |=> !data_hi_o && !data_lo_o;
  endproperty
  a_dead: assert property (p_dead) else $error("dead bit not idle");

  property p_stop;
    @(posedge clk) disable iff (!rst_n) s_code_done |=> state_q == S_CHK ##1 (reply_avail || reply_error) ##1 !tx_clk;
  endproperty
  a_stop: assert property (p_stop) else $error("return code did not end transfer");

  property p_bad_code;
    @(posedge clk) disable iff (!rst_n) (state_q == S_CHK && !code_ok(rc_hi_q, rc_lo_q)) |=> reply_error && !reply_avail;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("undefined return code not flagged");

  property p_bad_addr;
    @(posedge clk) disable iff (!rst_n)
      (state_q == S_IDLE && cmd_valid && is_xfer && !dec[4]) |=> ill_q && state_q == S_IDLE;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("invalid address not refused");

  property p_mask;
    @(posedge clk) disable iff (!rst_n) 1'b1 |=> ((int_q & $past(mask_int_q)) == 16'h0000);
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt pending");

  property p_wr_par;
    @(posedge clk) disable iff (!rst_n) (wr_valid && state_q == S_IDLE) |=> par_ok(buf_q[$past(wr_index)]);
  endproperty
  a_wr_par: assert property (p_wr_par) else $error("stored word parity wrong");

endmodule : dscl_channel

// file: test/dscl_pdev.sv
// Peripheral model: captures outgoing frames, returns codes and data
`timescale 1ns/1ps
module dscl_pdev
  import dscl_pkg::*;
(
  // Link
  input  wire logic        clk,
  input  wire logic        tx_clk,
  input  wire logic        hi_o,
  input  wire logic        lo_o,
  input  wire logic        oe,
  output logic             rx_clk,
  output logic             hi_q,
  output logic             lo_q,
  // Reply setup
  input  wire logic [7:0]  rc,
  input  wire logic [35:0] rw
);
  logic [399:0] cap_hi;
  logic [399:0] cap_lo;
  int           n;
  int           txr = 0;
  logic         act = 0;
  task automatic put(input logic [18:0] h, input logic [18:0] l, input int k);
    for (int b = 0; b < k; b++)
    begin
      hi_q = h[b];
      lo_q = l[b];
      #50 rx_clk = 1'b1;
      #100 rx_clk = 1'b0;
      #50;
    end
  endtask : put
  always @(posedge tx_clk) if (act) txr++;
  initial
  begin
    {rx_clk, hi_q, lo_q} = '0;
    forever
    begin
      @(posedge oe);
      n = 0;
      // Bits are taken on the rising transmit clock while the channel drives
      while (oe)
      begin
        @(posedge tx_clk or negedge oe);
        if (oe)
        begin
          cap_hi[n] = hi_o;
          cap_lo[n] = lo_o;
          n++;
        end
      end
      act = 1'b1;
      repeat (12) @(posedge clk);
      put({15'h0, rc[7:4]}, {15'h0, rc[3:0]}, 4);
      if (cap_hi[3:0] == CODE_B)
        repeat (cap_lo[3:0] == CODE_C ? BLK_WORDS : 1) put({1'b0, rw[35:18]}, {1'b0, rw[17:0]}, 19);
      hi_q = ~hi_q;
      lo_q = ~lo_q;
      act = 1'b0;
    end
  end
endmodule : dscl_pdev

// file: test/tb.sv
// Testbench: host command sequences against the channel and the peripheral model
`timescale 1ns/1ps
module tb;
  import dscl_pkg::*;
  localparam dscl_op_t   OPS [7] = '{OP_WR_WORD, OP_WR_CMD, OP_WR_BLOCK, OP_RD_WORD, OP_RD_STATUS, OP_RD_BLOCK, OP_EOT};
  localparam logic [7:0] SC [7] = '{8'h33, 8'h35, 8'h39, 8'h53, 8'h55, 8'h59, 8'h93};
  localparam int         NB [7] = '{23, 23, 308, 4, 4, 4, 4};
  localparam logic [7:0] RC [4] = '{8'h33, 8'h35, 8'h53, 8'h55};
  localparam logic [5:0] A36 [16] = '{6'h07, 6'h0B, 6'h0D, 6'h0E, 6'h15, 6'h16, 6'h19, 6'h1A,
                                      6'h25, 6'h26, 6'h29, 6'h2A, 6'h31, 6'h32, 6'h34, 6'h38};
  logic        clk = 0;
  logic        rst_n = 0;
  logic        cmd_valid = 0;
  dscl_cmd_t   cmd = '0;
  logic        wr_valid = 0;
  logic [3:0]  wr_index = 0;
  logic [31:0] wr_data = 0;
  logic [1:0]  rd_sel = 0;
  logic [3:0]  rd_index = 0;
  logic [15:0] req = 0;
  logic [7:0]  rc = 8'h33;
  logic [35:0] rw;
  logic [35:0] rd_data;
  logic [35:0] v;
  logic [15:0] pd_select;
  logic        busy, r_ok, r_err, tx_clk, rx_clk, h_o, h_oe, l_o, l_oe, h_q, l_q;
  int          failures = 0;
  int          check_count = 0;
  int          j;
  always #12.5 clk = ~clk;
  dscl_channel DUT (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .wr_valid(wr_valid),
    .wr_index(wr_index), .wr_data(wr_data), .rd_sel(rd_sel), .rd_index(rd_index), .io_inhibit(1'b0),
    .rd_data(rd_data), .busy(busy), .reply_avail(r_ok), .reply_error(r_err), .pd_select(pd_select),
    .tx_clk(tx_clk), .data_hi_o(h_o), .data_hi_oe(h_oe), .data_hi_i(h_oe ? h_o : h_q), .data_lo_o(l_o),
    .data_lo_oe(l_oe), .data_lo_i(l_oe ? l_o : l_q), .rx_clk(rx_clk), .req_in(req));
  dscl_pdev PD (.clk(clk), .tx_clk(tx_clk), .hi_o(h_o), .lo_o(l_o), .oe(h_oe), .rx_clk(rx_clk),
    .hi_q(h_q), .lo_q(l_q), .rc(rc), .rw(rw));
  function automatic logic [35:0] enc(input logic [31:0] w);
    for (int i = 0; i < 4; i++)
      enc[9*i+:9] = {~^w[8*i+:8], w[8*i+:8]};
  endfunction : enc
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input dscl_op_t o, input logic [5:0] a, input logic [17:0] x);
    @(negedge clk);
    cmd_valid = 1;
    cmd = {o, a, x};
    @(negedge clk);
    cmd_valid = 0;
  endtask : op
  task automatic rd(input logic [1:0] s, input logic [3:0] i);
    rd_sel = s;
    rd_index = i;
    repeat (2) @(negedge clk);
    v = rd_data;
  endtask : rd
  task automatic wt(input logic e);
    int k;
    k = 0;
    while (!(r_ok === 1'b1 || r_err === 1'b1) && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 4000)
    begin
      failures++;
      finish_test();
    end
    else
    begin
      chk({r_ok, r_err}, {~e, e});
      repeat (8) @(negedge clk);
    end
  endtask : wt
  task automatic pulse(input int i, input int c);
    req[i] = 1;
    repeat (c) @(negedge clk);
    req[i] = 0;
    repeat (8) @(negedge clk);
  endtask : pulse
  initial
  begin
    rw = enc(32'hA5C3_0F96);
    repeat (10) @(negedge clk);
    rst_n = 1;
    rd(RD_STATUS, 0);
    chk(v[12:0], 0);
    for (int i = 0; i < 16; i++)
    begin
      j = i % 7;
      rc = RC[i % 4];
      for (int w = 0; w < 16; w++)
      begin
        @(negedge clk);
        {wr_valid, wr_index, wr_data} = {1'b1, w[3:0], i[7:0], w[7:0], 16'hC35A};
      end
      @(negedge clk);
      wr_valid = 0;
      PD.txr = 0;
      op(OPS[j], A36[i], 0);
      chk(busy, 1);
      wt(0);
      chk({PD.cap_hi[3:0], PD.cap_lo[3:0]}, SC[j]);
      chk(PD.n, NB[j]);
      chk(pd_select, 16'h1 << i);
      chk(PD.txr != 0, 1);
      for (int w = 0; w < (NB[j] - 4) / 19; w++)
      begin
        chk({PD.cap_hi[4+19*w+:18], PD.cap_lo[4+19*w+:18]}, enc({i[7:0], w[7:0], 16'hC35A}));
        chk({PD.cap_hi[22+19*w], PD.cap_lo[22+19*w]}, 0);
      end
      if (SC[j][7:4] == CODE_B)
      begin
        rd(RD_BUF, j == 5 ? 15 : 0);
        chk(v, rw);
      end
      rd(RD_STATUS, 0);
      chk(v[6:0], {1'b0, rc[7:5], rc[3:1]});
    end
    rc = 8'h99;
    op(OP_WR_WORD, A36[1], 0);
    wt(1);
    rc = 8'h33;
    rw[0] = ~rw[0];
    op(OP_RD_WORD, A36[2], 0);
    wt(1);
    rd(RD_STATUS, 0);
    chk(v[11], 1);
    op(OP_WR_WORD, A36[3], 0);
    op(OP_RD_WORD, A36[4], 0);
    wt(0);
    rd(RD_STATUS, 0);
    chk({v[10], pd_select}, {1'b1, 16'h0008});
    op(OP_WR_WORD, 6'h00, 0);
    rd(RD_STATUS, 0);
    chk({v[10:9], v[6]}, 3'b110);
    op(OP_SET_OVR, A36[0], 0);
    op(OP_SET_MAINT, A36[0], 0);
    rd(RD_STATUS, 0);
    chk({v[12], v[7]}, 2'b11);
    op(OP_CLR_OVR, A36[0], 0);
    op(OP_CLR_MAINT, A36[0], 0);
    rd(RD_STATUS, 0);
    chk({v[12], v[7]}, 2'b00);
    pulse(2, 8);
    pulse(3, 18);
    pulse(4, 40);
    rd(RD_SR, 0);
    chk(v[31:0], 32'h0008_0004);
    rd(RD_INT, 0);
    chk(v[15:0], 16'h0010);
    op(OP_NOP, A36[0], {2'b11, 16'h001C});
    rd(RD_SR, 0);
    chk(v[31:0], 0);
    rd(RD_INT, 0);
    chk(v[15:0], 0);
    op(OP_LD_MINT, A36[0], 16'h0010);
    op(OP_LD_MSR, A36[0], 16'h0004);
    pulse(4, 40);
    pulse(2, 8);
    rd(RD_INT, 0);
    chk(v[15:0], 0);
    rd(RD_SR, 0);
    chk(v[31:0], 0);
    finish_test();
  end
endmodule : tb
